// *** rtl/pcwe_consts.vh ***
// constants for the panel control word encoder
`ifndef PCWE_CONSTS_VH
`define PCWE_CONSTS_VH
// ********************
// drive state codes
// ********************
`define PCWE_DRV_OPERATE 2'h0
`define PCWE_DRV_MUTE 2'h1
`define PCWE_DRV_TRANSMIT 2'h2
// ********************
// mode field codes, bits 31..25
// ********************
`define PCWE_MODE_CW 7'h48
`define PCWE_MODE_AM6 7'h01
`define PCWE_MODE_USB20 7'h04
`define PCWE_MODE_USBSUPP 7'h00
`define PCWE_MODE_LSB20 7'h0C
`define PCWE_MODE_LSBSUPP 7'h08
`define PCWE_MODE_ISB20 7'h14
`define PCWE_MODE_ISBSUPP 7'h10
// ********************
// bit positions in the incoming display data
// ********************
`define PCWE_DSP_RESET 18
`define PCWE_DSP_SYM 32
`define PCWE_DSP_DRV_LO 33
`define PCWE_DSP_DRV_HI 34
`define PCWE_DSP_MODE_HI 31
`define PCWE_DSP_MODE_LO 25
// ********************
// register map, byte offsets
// ********************
`define PCWE_REG_CTRL 12'h000
`define PCWE_REG_STATUS 12'h004
`define PCWE_REG_WORD 12'h008
// ********************
// timing and counts
// ********************
`define PCWE_DEB_NS 20000000
`define PCWE_CLK_NS 50
`define PCWE_PAIR_COUNT 2'h2
`define PCWE_CTRL_RST 2'h0
`endif

// *** rtl/pcwe_encoder.v ***
// panel control word encoder: drive state, mode field, reset bit, entry enable
//
// The APB interface to the registers and the register addresses were decided locally.
`include "pcwe_consts.vh"
`default_nettype none

// Behaviour
// - one-of-four drive lamp, only while power good
// - symmetrical bit: zero, loaded on word3, cleared by mode
// - entry enable is AND of three inputs
// - inhibit-entry low: accept entry, suppress outgoing data
// - external entry: accept entry, keep sending data
// - control buttons gated by panel enable
// - drive code 00/01/10, external switches override
// - frequency change sets hold latch, lamp, new data
// - frequency change clears word-present counter
// - reset press clears hold, sets frequency new data
// - reset release pulses bit 18 and new data
// - bit 18 cleared after one frame pair
// - strobe clears new data, makes display pulse
// - display reset bit sets bit 18 on word3
// - 7-bit mode field held, from display or panel
// - mode field bit map per mode table
// - mode press encodes, loads code, sets new data
// - new data latch stops counter at word3 enable
module pcwe_encoder #(
  parameter DEB_CYCLES = (`PCWE_DEB_NS + `PCWE_CLK_NS - 1) / `PCWE_CLK_NS,
  parameter NBTN = 14
) (
  // clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // push-buttons, raw: 0..7 mode, 8 mute, 9 operate, 10 transmit, 11 reset,
  // 12 ext transmit, 13 ext mute (12/13 are levels, not gated)
  input wire [NBTN-1:0] button_raw,
  // status and entry inputs
  input wire power_good,
  input wire panel_enable,
  input wire ext_entry_inhibit_n,
  input wire ext_entry,
  // control processor side
  input wire word3_enable,
  input wire ctrl_strobe_n,
  input wire in_word3_pulse,
  input wire [47:0] display_data,
  input wire freq_change,
  // outputs
  output reg [3:0] drive_lamp,
  output reg entry_enable,
  output reg out_data_inhibit,
  output reg accept_entry,
  output reg freq_hold,
  output reg reset_lamp,
  output reg freq_new_data,
  output reg word_cnt_clear,
  output reg new_data_stop,
  output reg freq_display_pulse,
  output reg [34:16] mode_word
);

  // ********************
  // button synchronise and debounce
  // ********************
  reg [NBTN-1:0] sync1_ff;
  reg [NBTN-1:0] sync2_ff;
  reg [NBTN-1:0] stable_ff;
  reg [NBTN-1:0] press_ff;
  reg [NBTN-1:0] release_ff;
  reg [31:0] deb_cnt_ff [0:NBTN-1];

  genvar gi;
  generate
    for (gi = 0; gi < NBTN; gi = gi + 1) begin : g_btn
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          stable_ff[gi] <= 1'b0;
          press_ff[gi] <= 1'b0;
          release_ff[gi] <= 1'b0;
          deb_cnt_ff[gi] <= 32'h0;
        end else if (clk_en) begin
          sync1_ff[gi] <= button_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          press_ff[gi] <= 1'b0;
          release_ff[gi] <= 1'b0;
          // a level must hold for the whole debounce time before it counts
          if (sync2_ff[gi] == stable_ff[gi]) begin
            deb_cnt_ff[gi] <= 32'h0;
          end else if (deb_cnt_ff[gi] >= DEB_CYCLES - 1) begin
            deb_cnt_ff[gi] <= 32'h0;
            stable_ff[gi] <= sync2_ff[gi];
            press_ff[gi] <= sync2_ff[gi];
            release_ff[gi] <= ~sync2_ff[gi];
          end else begin
            deb_cnt_ff[gi] <= deb_cnt_ff[gi] + 32'h1;
          end
        end
      end
    end
  endgenerate

  // ********************
  // gated presses, ungated external levels
  // ********************
  wire [7:0] mode_press = press_ff[7:0] & {8{panel_enable}};
  wire any_mode = |mode_press;
  wire mute_press = press_ff[8] & panel_enable;
  wire oper_press = press_ff[9] & panel_enable;
  wire xmit_press = press_ff[10] & panel_enable;
  wire rst_press = press_ff[11] & panel_enable;
  wire rst_release = release_ff[11] & panel_enable;
  wire ext_xmit = stable_ff[12];
  wire ext_mute = stable_ff[13];

  // ********************
  // registers and state
  // ********************
  reg [1:0] ctrl_ff;
  reg [1:0] panel_drv_ff;
  reg sym_ff;
  reg [6:0] mode_code_ff;
  reg bit18_ff;
  reg [1:0] pair_cnt_ff;
  reg new_data_ff;
  reg strobe_n_d_ff;
  reg [6:0] nxt_code;

  // priority encoder, highest button wins
  always @* begin
    nxt_code = `PCWE_MODE_USBSUPP;
    if (mode_press[7]) nxt_code = `PCWE_MODE_ISBSUPP;
    else if (mode_press[6]) nxt_code = `PCWE_MODE_ISB20;
    else if (mode_press[5]) nxt_code = `PCWE_MODE_LSBSUPP;
    else if (mode_press[4]) nxt_code = `PCWE_MODE_LSB20;
    else if (mode_press[3]) nxt_code = `PCWE_MODE_USBSUPP;
    else if (mode_press[2]) nxt_code = `PCWE_MODE_USB20;
    else if (mode_press[1]) nxt_code = `PCWE_MODE_AM6;
    else if (mode_press[0]) nxt_code = `PCWE_MODE_CW;
  end

  // external switches override the panel selection
  wire [1:0] drv_code = ext_xmit ? `PCWE_DRV_TRANSMIT :
                        ext_mute ? `PCWE_DRV_MUTE : panel_drv_ff;
  wire strobe_rise = ctrl_strobe_n & ~strobe_n_d_ff;
  wire disp_pulse = strobe_rise;
  wire pair_tick = disp_pulse & word3_enable;
  wire set_new = any_mode | mute_press | oper_press | xmit_press |
                 rst_press | rst_release | freq_change;
  wire apb_wr = psel & penable & pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `PCWE_CTRL_RST;
      panel_drv_ff <= `PCWE_DRV_OPERATE;
      sym_ff <= 1'b0;
      mode_code_ff <= `PCWE_MODE_USBSUPP;
      bit18_ff <= 1'b0;
      pair_cnt_ff <= 2'h0;
      new_data_ff <= 1'b0;
      strobe_n_d_ff <= 1'b1;
      freq_hold <= 1'b0;
      freq_new_data <= 1'b0;
      word_cnt_clear <= 1'b0;
    end else if (clk_en) begin
      strobe_n_d_ff <= ctrl_strobe_n;
      word_cnt_clear <= freq_change;
      if (apb_wr && paddr == `PCWE_REG_CTRL) begin
        ctrl_ff <= pwdata[1:0];
      end
      // drive state: panel buttons or display data in check/remote
      if (xmit_press) panel_drv_ff <= `PCWE_DRV_TRANSMIT;
      else if (mute_press) panel_drv_ff <= `PCWE_DRV_MUTE;
      else if (oper_press) panel_drv_ff <= `PCWE_DRV_OPERATE;
      else if (in_word3_pulse && !panel_enable) begin
        panel_drv_ff <= display_data[`PCWE_DSP_DRV_HI:`PCWE_DSP_DRV_LO];
      end
      // symmetrical bit; a mode press outranks the load
      if (any_mode) sym_ff <= 1'b0;
      else if (in_word3_pulse) sym_ff <= display_data[`PCWE_DSP_SYM];
      // mode field
      if (any_mode) mode_code_ff <= nxt_code;
      else if (in_word3_pulse && !panel_enable) begin
        mode_code_ff <= display_data[`PCWE_DSP_MODE_HI:`PCWE_DSP_MODE_LO];
      end
      // frequency hold latch; a change in the same cycle outranks reset
      if (freq_change) freq_hold <= 1'b1;
      else if (rst_press) freq_hold <= 1'b0;
      if (rst_press) freq_new_data <= 1'b1;
      else if (ctrl_strobe_n == 1'b0) freq_new_data <= 1'b0;
      // bit 18 and its frame-pair counter
      if (rst_release || (in_word3_pulse && display_data[`PCWE_DSP_RESET])) begin
        bit18_ff <= 1'b1;
        pair_cnt_ff <= 2'h0;
      end else if (bit18_ff && pair_tick) begin
        if (pair_cnt_ff == `PCWE_PAIR_COUNT - 2'h1) begin
          bit18_ff <= 1'b0;
          pair_cnt_ff <= 2'h0;
        end else begin
          pair_cnt_ff <= pair_cnt_ff + 2'h1;
        end
      end
      // new data latch: set wins over strobe clear
      if (set_new) new_data_ff <= 1'b1;
      else if (strobe_rise && word3_enable) new_data_ff <= 1'b0;
    end
  end

  // ********************
  // registered outputs
  // ********************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_lamp <= 4'h0;
      entry_enable <= 1'b0;
      out_data_inhibit <= 1'b0;
      accept_entry <= 1'b0;
      reset_lamp <= 1'b0;
      new_data_stop <= 1'b0;
      freq_display_pulse <= 1'b0;
      mode_word <= 19'h0;
    end else if (clk_en) begin
      // drive lamps go dark on power failure to spare the lamp supply
      drive_lamp <= power_good ? (4'h1 << drv_code) : 4'h0;
      entry_enable <= panel_enable & ext_entry_inhibit_n & ext_entry;
      out_data_inhibit <= ~ext_entry_inhibit_n | ctrl_ff[0];
      accept_entry <= ~ext_entry_inhibit_n | ext_entry | ctrl_ff[1];
      reset_lamp <= freq_hold;
      new_data_stop <= new_data_ff & word3_enable;
      freq_display_pulse <= disp_pulse;
      mode_word <= {drv_code, sym_ff, mode_code_ff, 6'h0, bit18_ff, 2'h0};
    end
  end

  // ********************
  // apb slave, zero wait states
  // ********************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= (paddr != `PCWE_REG_CTRL) && (paddr != `PCWE_REG_STATUS) &&
                   (paddr != `PCWE_REG_WORD);
        case (paddr)
          `PCWE_REG_CTRL: prdata <= {30'h0, ctrl_ff};
          `PCWE_REG_STATUS: prdata <= {27'h0, pair_cnt_ff, new_data_ff,
                                       bit18_ff, freq_hold};
          `PCWE_REG_WORD: prdata <= {13'h0, drv_code, sym_ff, mode_code_ff,
                                     6'h0, bit18_ff, 2'h0};
          default: prdata <= 32'h0;
        endcase
      end else begin
        pready <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/pcwe_encoder_props.sv ***
// assertions for the panel control word encoder
`default_nettype none
module pcwe_encoder_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // inputs
  input wire logic psel,
  input wire logic penable,
  input wire logic power_good,
  input wire logic panel_enable,
  input wire logic ext_entry_inhibit_n,
  input wire logic ext_entry,
  input wire logic ctrl_strobe_n,
  input wire logic freq_change,
  input wire logic word3_enable,
  // outputs
  input wire logic new_data_stop,
  input wire logic pready,
  input wire logic [3:0] drive_lamp,
  input wire logic entry_enable,
  input wire logic out_data_inhibit,
  input wire logic accept_entry,
  input wire logic freq_hold,
  input wire logic reset_lamp,
  input wire logic word_cnt_clear,
  input wire logic freq_display_pulse,
  input wire logic [34:16] mode_word
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence strobe_end;
    $rose(ctrl_strobe_n);
  endsequence
  a_apb_answer: assert property (apb_setup |=> pready) else $error("no answer after setup");
  a_entry_and: assert property ($past(presetn) |->
    entry_enable == $past(panel_enable && ext_entry_inhibit_n && ext_entry))
    else $error("entry enable wrong");
  a_inhibit_entry: assert property ($past(presetn) && !$past(ext_entry_inhibit_n) |->
    out_data_inhibit && accept_entry) else $error("inhibit entry wrong");
  a_ext_accept: assert property ($past(presetn) && $past(ext_entry) |->
    accept_entry) else $error("external entry refused");
  a_lamp_dark: assert property ($past(presetn) && !$past(power_good) |->
    drive_lamp == 4'h0) else $error("lamp lit without power");
  a_lamp_single: assert property ($past(presetn) && $past(power_good) |->
    $onehot(drive_lamp)) else $error("lamp not one of four");
  a_drive_legal: assert property (mode_word[34:33] != 2'h3)
    else $error("illegal drive code");
  a_mode_legal: assert property (mode_word[31:25] inside
    {7'h48, 7'h01, 7'h04, 7'h00, 7'h0C, 7'h08, 7'h14, 7'h10}) else $error("bad mode code");
  a_freq_hold: assert property (freq_change |-> ##[1:2] (freq_hold && reset_lamp))
    else $error("hold latch not set");
  a_cnt_clear: assert property (freq_change |-> ##[1:2] word_cnt_clear)
    else $error("counter clear missing");
  a_disp_pulse: assert property (strobe_end |-> ##[0:2] freq_display_pulse)
    else $error("display pulse missing");
  a_pulse_once: assert property (freq_display_pulse |=> !freq_display_pulse)
    else $error("display pulse too long");
  a_stop_gated: assert property ($past(presetn) && !$past(word3_enable) |->
    !new_data_stop) else $error("stop outside word 3");
endmodule
bind pcwe_encoder pcwe_encoder_props u_pcwe_encoder_props (.pclk, .presetn, .psel,
  .penable, .power_good, .panel_enable, .ext_entry_inhibit_n, .ext_entry, .ctrl_strobe_n,
  .freq_change, .word3_enable, .new_data_stop, .pready, .drive_lamp, .entry_enable,
  .out_data_inhibit, .accept_entry,
  .freq_hold, .reset_lamp, .word_cnt_clear, .freq_display_pulse, .mode_word);
`default_nettype wire

// *** tb/pcwe_proc_model.sv ***
// control processor card model: frame strobes and display words
`default_nettype none
module pcwe_proc_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench requests
  input wire logic frame_req,
  input wire logic load_req,
  input wire logic [47:0] load_data,
  // encoder side
  output wire logic word3_enable,
  output wire logic ctrl_strobe_n,
  output var logic in_word3_pulse,
  output var logic [47:0] display_data
);
  logic [2:0] step_ff;
  // strobe ends while word 3 is still enabled, so every frame counts
  assign word3_enable = step_ff != 3'h0;
  assign ctrl_strobe_n = step_ff != 3'h2;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_ff <= 3'h0;
      in_word3_pulse <= 1'b0;
      display_data <= 48'h0;
    end else begin
      in_word3_pulse <= load_req;
      if (load_req) begin
        display_data <= load_data;
      end
      if (frame_req || step_ff != 3'h0) begin
        step_ff <= (step_ff == 3'h3) ? 3'h0 : step_ff + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_pcwe_encoder.sv ***
// testbench for the panel control word encoder
`default_nettype none
module tb_pcwe_encoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEB = 4;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [13:0] button_raw = 14'h0;
  logic power_good = 1'b1, panel_enable = 1'b1, ext_entry_inhibit_n = 1'b1, ext_entry = 1'b0;
  logic freq_change = 1'b0, frame_req = 1'b0, load_req = 1'b0, err;
  logic [47:0] load_data = 48'h0;
  wire logic word3_enable, ctrl_strobe_n, in_word3_pulse, pready, pslverr, entry_enable;
  wire logic out_data_inhibit, accept_entry, freq_hold, reset_lamp, freq_new_data;
  wire logic [47:0] display_data;
  wire logic [31:0] prdata;
  wire logic [3:0] drive_lamp;
  wire logic [34:16] mode_word;
  int error_cnt = 0, compares = 0, cycles = 0;
  int drv_btn [3] = '{10, 8, 9};
  logic [1:0] drv_exp [3] = '{2'h2, 2'h1, 2'h0};
  logic [6:0] mode_tab [8] = '{7'h48, 7'h01, 7'h04, 7'h00, 7'h0C, 7'h08, 7'h14, 7'h10};
  pcwe_encoder #(.DEB_CYCLES(DEB)) u_pcwe_encoder (.pclk, .presetn, .clk_en(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .button_raw, .power_good,
    .panel_enable, .ext_entry_inhibit_n, .ext_entry, .word3_enable, .ctrl_strobe_n,
    .in_word3_pulse, .display_data, .freq_change, .drive_lamp, .entry_enable, .out_data_inhibit,
    .accept_entry, .freq_hold, .reset_lamp, .freq_new_data, .word_cnt_clear(),
    .new_data_stop(), .freq_display_pulse(), .mode_word);
  pcwe_proc_model u_pcwe_proc_model (.pclk, .presetn, .frame_req, .load_req, .load_data,
    .word3_enable, .ctrl_strobe_n, .in_word3_pulse, .display_data);
  initial forever #25 pclk = ~pclk;
  task automatic complete_run();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic look();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  // request held until the rising edge that samples pready high; answer taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic hold(input int b, input logic on);
    @(posedge pclk);
    button_raw[b] <= on;
    repeat (DEB + 6) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic press(input int b);
    hold(b, 1'b1);
    hold(b, 1'b0);
  endtask
  task automatic frame();
    @(posedge pclk);
    frame_req <= 1'b1;
    @(posedge pclk);
    frame_req <= 1'b0;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1, "ctrl readback");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 1, "unmapped error");
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      {panel_enable, ext_entry_inhibit_n, ext_entry} <= i[2:0];
      look();
      chk(entry_enable, &i[2:0], "entry enable");
      chk(accept_entry, !i[1] || i[0], "accept entry");
      chk(out_data_inhibit, !i[1], "out inhibit");
    end
    foreach (drv_btn[k]) begin
      press(drv_btn[k]);
      chk(mode_word[34:33], drv_exp[k], "drive code");
      chk(drive_lamp, 4'h1 << drv_exp[k], "drive lamp");
    end
    hold(12, 1'b1);
    chk(mode_word[34:33], 2'h2, "ext transmit");
    hold(12, 1'b0);
    hold(13, 1'b1);
    chk(mode_word[34:33], 2'h1, "ext mute");
    hold(13, 1'b0);
    @(posedge pclk);
    power_good <= 1'b0;
    panel_enable <= 1'b0;
    look();
    chk(drive_lamp, 4'h0, "lamp off");
    press(10);
    chk(mode_word[34:33], 2'h0, "gated press");
    @(posedge pclk);
    power_good <= 1'b1;
    load_data <= 48'h0003_2804_0000;
    load_req <= 1'b1;
    @(posedge pclk);
    load_req <= 1'b0;
    look();
    chk(mode_word[34:32], 3'h3, "display drive sym");
    chk(mode_word[31:25], 7'h14, "display mode");
    chk(mode_word[18], 1, "display reset");
    frame();
    chk(mode_word[18], 1, "bit18 one frame");
    frame();
    chk(mode_word[18], 0, "bit18 pair");
    @(posedge pclk);
    panel_enable <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      press(m);
      chk(mode_word[31:25], mode_tab[m], "mode field");
      chk(mode_word[32], 0, "sym cleared");
    end
    @(posedge pclk);
    freq_change <= 1'b1;
    @(posedge pclk);
    freq_change <= 1'b0;
    look();
    chk({freq_hold, reset_lamp}, 2'h3, "hold and lamp");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], 3'h5, "status after change");
    frame();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2], 0, "new data sent");
    press(11);
    chk({freq_hold, reset_lamp, freq_new_data, mode_word[18]}, 4'h3, "reset");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], 3'h6, "status after reset");
    complete_run();
  end
endmodule
`default_nettype wire
